// file: design/sram_ctrl_pkg.sv
package sram_ctrl_pkg;

  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int ADDR_W = 14;
  localparam int DATA_W = 4;
  localparam int WORDS = 16384;

  // ****************************************
  // Timing at the system clock rate
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  // Read access time in ns; the slowest grade is assumed.
  localparam int T_ACCESS_NS = 55;
  // Write pulse width in ns; the slowest grade is assumed.
  localparam int T_WP_NS = 40;
  // Output turn-off after write enable falls, in ns.
  localparam int T_WZ_NS = 25;
  // Cycle counts round up to whole clock periods.
  localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WZ_CYC = (T_WZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // ****************************************
  // Controller states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ACC,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END
  } ctrl_state_t;

endpackage : sram_ctrl_pkg

// file: design/sram_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - Read: write enable high, select and enable low.
// - Write starts at later falling select/write enable.
// - Master drives data only after outputs off.
// - Address changes only with select or write high.
// - Data captured on write enable rising edge.
// - Select-ended write captures data, outputs stay off.
// - Fast write: output enable high, select low.
module sram_ctrl
  import sram_ctrl_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // User request port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  // Memory pins
  output logic [AW-1:0] word_address,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic wr_en_n,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_n
);

  // ****************************************
  // State and pin registers
  // ****************************************
  ctrl_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] wdata_reg;
  logic cs_n_reg, oe_n_reg, we_n_reg, dq_oe_n_reg;
  logic rsp_valid_reg;
  logic [DW-1:0] rdata_reg;

  // ****************************************
  // Decode
  // ****************************************
  // A request is taken only in idle, so the address never moves while
  // select and write enable are both low.
  wire take = (state_reg == ST_IDLE) && req_valid;
  wire cnt_done = (cnt_reg == '0);
  wire rd_done = (state_reg == ST_RD_ACC) && cnt_done;
  assign req_ready = (state_reg == ST_IDLE);
  assign word_address = addr_reg;
  assign chip_sel_n = cs_n_reg;
  assign out_en_n = oe_n_reg;
  assign wr_en_n = we_n_reg;
  assign dq_out = wdata_reg;
  assign dq_oe_n = dq_oe_n_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rdata_reg;

  // Next-state logic. Writes use the fast style: output enable stays high
  // so the memory never drives the bus and no contention can arise.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!cnt_done) begin
      cnt_next = cnt_reg - 1'b1;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (take && req_write) begin
          state_next = ST_WR_SETUP;
          cnt_next = '0;
        end else if (take) begin
          state_next = ST_RD_ACC;
          cnt_next = CNT_W'(ACC_CYC);
        end
      end
      ST_RD_ACC: begin
        if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_WR_SETUP: begin
        state_next = ST_WR_PULSE;
        cnt_next = CNT_W'(WP_CYC);
      end
      ST_WR_PULSE: begin
        if (cnt_done) begin
          state_next = ST_WR_END;
        end
      end
      ST_WR_END: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // In a write, select falls one full cycle before write enable and rises one cycle after it, which covers every setup,
  // hold and turn-off figure at this clock rate.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      dq_oe_n_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rsp_valid_reg <= rd_done;
      if (take) begin
        addr_reg <= req_addr;
        wdata_reg <= req_wdata;
      end
      if (rd_done) begin
        rdata_reg <= dq_in;
      end
      // Select, output enable, write enable and data drive per state.
      cs_n_reg <= !(state_next != ST_IDLE);
      oe_n_reg <= !(state_next == ST_RD_ACC);
      we_n_reg <= !(state_next == ST_WR_PULSE);
      dq_oe_n_reg <= !(state_next == ST_WR_PULSE || state_next == ST_WR_END);
    end
  end

  // ****************************************
  // Derived check latencies
  // ****************************************
  // A read answers two cycles after the access count: one cycle while the
  // count sits at zero and one to register the sampled word.
  localparam int RD_LAT = ACC_CYC + 2;
  // Write enable stays low for the pulse count plus the cycle in which the count sits at zero.
  localparam int WE_LOW = WP_CYC + 1;

  // ****************************************
  // Checks: bus ownership
  // ****************************************
  // The memory's output enable stays high whenever the controller drives.
  a_no_contention: assert property (@(posedge clk_sys) disable iff (rst)
    !dq_oe_n |-> out_en_n)
    else $error("controller drives bus while memory output enabled");
  // Write pulses only in the fast style, selected with outputs disabled.
  a_fast_write_oe: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_en_n |-> (out_en_n && !chip_sel_n))
    else $error("write pulse without select low and output enable high");
  // Reads only with write enable high, selected, and the bus released.
  a_read_pins: assert property (@(posedge clk_sys) disable iff (rst)
    !out_en_n |-> (wr_en_n && !chip_sel_n && dq_oe_n))
    else $error("read without write enable high and select low");

  // ****************************************
  // Checks: write sequence
  // ****************************************
  // The address must not move inside a write pulse.
  a_addr_stable: assert property (@(posedge clk_sys) disable iff (rst)
    (!chip_sel_n && !wr_en_n) |=> $stable(word_address) || wr_en_n)
    else $error("address moved during write");
  // The address only moves once select or write enable was already high.
  a_addr_sel: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(word_address) |-> $past(chip_sel_n) || $past(wr_en_n))
    else $error("address moved while select and write enable were low");
  // Data is still driven, unchanged, when write enable rises.
  a_data_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(wr_en_n) |-> !dq_oe_n && $stable(dq_out))
    else $error("write data not held at end of write");
  // A write starts only once select has settled low and data is driven.
  a_write_setup: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(wr_en_n) |-> !$past(chip_sel_n) && !dq_oe_n)
    else $error("write began before select settled");
  // The pulse lasts the full count, long enough for the slowest grade.
  a_write_len: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(wr_en_n) |-> ##WE_LOW $rose(wr_en_n))
    else $error("write pulse length wrong");
  // Select never rises inside a pulse, so no write ends on select; the bus
  // is released on that same edge, after the memory has captured.
  a_sel_end: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(chip_sel_n) |-> wr_en_n && $past(wr_en_n))
    else $error("select rose while write enable was low");

  // ****************************************
  // Checks: read answers and idle
  // ****************************************
  // The answer comes a fixed time after the request is taken.
  a_read_resp: assert property (@(posedge clk_sys) disable iff (rst)
    (req_ready && req_valid && !req_write) |-> ##RD_LAT rsp_valid)
    else $error("read response not on time");
  // The answer strobe is a single-cycle pulse.
  a_resp_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    rsp_valid |=> !rsp_valid)
    else $error("read response longer than one cycle");
  // The returned word only changes together with the answer strobe.
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(rsp_rdata) |-> rsp_valid)
    else $error("read data changed without a response");
  // An idle controller leaves the memory deselected in standby.
  a_idle_desel: assert property (@(posedge clk_sys) disable iff (rst)
    (req_ready && !req_valid) |=> chip_sel_n)
    else $error("chip not deselected when idle");

endmodule : sram_ctrl

// file: test/sram_word_model.sv
`timescale 1ns/1ps
// ****************************************
// Behavioural 16K x 4 static memory
// ****************************************
module sram_word_model
  import sram_ctrl_pkg::*;
(
  // Pins
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic [DATA_W-1:0] dq_bus,
  // Drive toward the bus
  output logic [DATA_W-1:0] mem_q,
  output logic mem_oe_n
);
  // Cells hold their value until written again; reads never touch them.
  logic [DATA_W-1:0] cells [WORDS];
  // Drive only when selected, enabled and not writing.
  assign mem_oe_n = !(!chip_sel_n && !out_en_n && wr_en_n);
  // Zero access delay, the fastest legal answer.
  assign mem_q = cells[word_address];
  // Capture on the earlier rising control while the other is still low.
  always @(posedge wr_en_n) if (!chip_sel_n) cells[word_address] <= dq_bus;
  always @(posedge chip_sel_n) if (!wr_en_n) cells[word_address] <= dq_bus;
endmodule : sram_word_model

// file: test/sram_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module sram_ctrl_tb;
  import sram_ctrl_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 14'h0000;
  logic [DATA_W-1:0] req_wdata = 4'h0, float_pat = 4'h5;
  wire req_ready, rsp_valid, chip_sel_n, out_en_n, wr_en_n, dq_oe_n, mem_oe_n;
  wire [DATA_W-1:0] rsp_rdata, dq_out, mem_q, dq_in;
  wire [ADDR_W-1:0] word_address;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  // A released bus shows a changing pattern, so stale data never reads back.
  assign dq_in = !dq_oe_n ? dq_out : (!mem_oe_n ? mem_q : float_pat);
  sram_ctrl uut (.clk_sys, .rst, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .word_address, .chip_sel_n, .out_en_n,
    .wr_en_n, .dq_in, .dq_out, .dq_oe_n);
  sram_word_model mem (.word_address, .chip_sel_n, .out_en_n, .wr_en_n,
    .dq_bus(dq_in), .mem_q, .mem_oe_n);
  initial forever #50 clk_sys = ~clk_sys;
  // Cycle ceiling cuts a hang short.
  always @(posedge clk_sys) begin
    float_pat <= ~float_pat + 4'h3;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  // One request; waits for ready again under a bound.
  task automatic xfer(input logic wr, input logic [13:0] a, input logic [3:0] d,
      output logic [3:0] q);
    int n;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
      if (wr) `CHK("out_en_n", 1'b1, out_en_n)
      else `CHK("dq_oe_n", 1'b1, dq_oe_n)
      if (rsp_valid === 1'b1) begin
        q = rsp_rdata;
        // Seen just after its launching edge, one edge before it is sampled.
        `CHK("latency", ACC_CYC + 1, n)
      end
    end while (req_ready !== 1'b1 && n < 12);
    `CHK("req_ready", 1'b1, req_ready)
  endtask : xfer
  task automatic t_idle;
    `CHK("chip_sel_n", 1'b1, chip_sel_n)
    `CHK("wr_en_n", 1'b1, wr_en_n)
  endtask : t_idle
  task automatic t_boundary;
    logic [3:0] q;
    xfer(1'b1, 14'h0000, 4'ha, q);
    xfer(1'b1, 14'h3fff, 4'h5, q);
    xfer(1'b0, 14'h0000, 4'h0, q);
    `CHK("rd_low", 4'ha, q)
    xfer(1'b0, 14'h3fff, 4'h0, q);
    `CHK("rd_top", 4'h5, q)
  endtask : t_boundary
  task automatic t_overwrite;
    logic [3:0] q;
    xfer(1'b1, 14'h1234, 4'h3, q);
    xfer(1'b1, 14'h1234, 4'hc, q);
    xfer(1'b0, 14'h1234, 4'h0, q);
    `CHK("rewrite", 4'hc, q)
  endtask : t_overwrite
  task automatic t_reread;
    logic [3:0] q;
    xfer(1'b1, 14'h0155, 4'h9, q);
    xfer(1'b0, 14'h0155, 4'h0, q);
    xfer(1'b0, 14'h0155, 4'h0, q);
    `CHK("reread", 4'h9, q)
  endtask : t_reread
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_idle();
    t_boundary();
    t_overwrite();
    t_reread();
    t_idle();
    wrap_up();
  end
endmodule : sram_ctrl_tb
